// file: hw/boot_cmd_parser.sv
// Serial boot mode command interpreter with two-entry reply buffer
`timescale 1ns/1ps

// Notes on behaviour
// - Each operation starts from a sequence led by its code byte.
// - Codes b0..b3 echo themselves, then select 9600..57600 bps.
// - Page read ff takes two address bytes, returns 256 bytes ascending.
// - Page program 41 takes two address bytes and 256 data bytes.
// - Busy stays high after page program until ready for more.
// - Read status 70 returns primary then secondary status byte.
// - Clear status 50 clears error bits, busy falls when done.
// - Erase all a7 needs confirm d0, then erases unlocked blocks.
// - Without verified ID only 70, f5, fb and baud codes accepted.
// - A wholly blank flash accepts every command without ID check.
// - Download fa takes size low, size high, checksum, then data.
// - Version fb returns eight version bytes as bytes two to nine.
// - Boot ROM output fc takes two address bytes, returns 256 bytes.
// - Lock commands 71 read, 77 program with d0, 7a enable, 75 disable.
// - Reply bytes come from the device, all others from programmer.
// - Block erase 20 takes two address bytes, starts only on d0.
// - ID check f5 takes three address bytes, count, then ID bytes.
// - Check data fd returns low then high CRC of programmed data.
module boot_cmd_parser (
  input  wire logic        CLOCK_I,            // 50 MHz clock
  input  wire logic        RST_I,              // Synchronous reset
  input  wire logic        RX_VALID_I,         // Received byte valid
  input  wire logic [7:0]  RX_DATA_I,          // Received byte
  output logic             RX_READY_O,         // Parser takes byte
  output logic             TX_VALID_O,         // Reply byte valid
  output logic      [7:0]  TX_DATA_O,          // Reply byte
  input  wire logic        TX_READY_I,         // Transmitter takes byte
  output logic             BUSY_O,             // Busy indicator pin
  output logic      [1:0]  BAUD_SEL_O,         // 0..3: 9600..57600
  input  wire logic        BLANK_I,            // Whole flash blank
  input  wire logic [7:0]  PRIMARY_STATUS_I,   // Primary status byte
  output logic             MEM_REQ_O,          // Operation request
  output logic      [3:0]  MEM_OP_O,           // Operation code
  output logic      [23:0] MEM_ADDR_O,         // Operation address
  output logic      [7:0]  MEM_WDATA_O,        // Write data
  input  wire logic        MEM_ACK_I,          // Operation done
  input  wire logic [7:0]  MEM_RDATA_I         // Read data
);

  boot_cmd_pkg::state_t  state_q;
  boot_cmd_pkg::mem_op_t op_q;
  logic [7:0]  cmd_q;
  logic [15:0] cnt_q;
  logic [15:0] len_q;
  logic [23:0] addr_q;
  logic [23:0] maddr_q;
  logic [7:0]  byte_q;
  logic [7:0]  chk_q;
  logic [7:0]  sum_q;
  logic        final_q;
  logic        req_q;
  logic        busy_q;
  logic        mis_q;
  logic [1:0]  id_q;
  logic        boot_q;
  logic        sum_ok_q;
  logic [15:0] crc_q;
  logic [1:0]  baud_q;
  logic [7:0]  buf_q [2];
  logic [1:0]  fill_q;
  logic        rd_q;
  logic        wr_q;
  logic        rx_take;
  logic        full;
  logic        push;
  logic        pop;
  logic [7:0]  push_data;
  logic [7:0]  local_byte;
  logic        out_mem;
  logic        out_last;
  logic        cmd_ok;
  logic [7:0]  sec_status;
  logic [2:0]  ver_idx;

  // Header bytes that follow the code
  function automatic logic [15:0] hdr_len(input logic [7:0] c);
    unique case (c)
      boot_cmd_pkg::CMD_PAGE_READ, boot_cmd_pkg::CMD_PAGE_PROG,
      boot_cmd_pkg::CMD_BLK_ERASE, boot_cmd_pkg::CMD_RD_LOCK,
      boot_cmd_pkg::CMD_LOCK_PROG, boot_cmd_pkg::CMD_BOOT_OUT:
        return boot_cmd_pkg::HDR_ADDR_LEN;
      boot_cmd_pkg::CMD_ID_CHECK: return boot_cmd_pkg::HDR_ID_LEN;
      boot_cmd_pkg::CMD_DOWNLOAD: return boot_cmd_pkg::HDR_DL_LEN;
      default:                    return 16'h0000;
    endcase
  endfunction

  // Reply bytes sent by the device
  function automatic logic [15:0] out_len(input logic [7:0] c);
    unique case (c)
      boot_cmd_pkg::CMD_PAGE_READ,
      boot_cmd_pkg::CMD_BOOT_OUT:  return boot_cmd_pkg::PAGE_LEN;
      boot_cmd_pkg::CMD_RD_STATUS,
      boot_cmd_pkg::CMD_RD_CHECK:  return boot_cmd_pkg::PAIR_LEN;
      boot_cmd_pkg::CMD_VERSION:   return boot_cmd_pkg::VER_LEN;
      default:                     return boot_cmd_pkg::ONE_LEN;
    endcase
  endfunction

  // Known codes only; anything else is dropped
  function automatic logic known(input logic [7:0] c);
    unique case (c)
      boot_cmd_pkg::CMD_PAGE_READ, boot_cmd_pkg::CMD_PAGE_PROG,
      boot_cmd_pkg::CMD_BLK_ERASE, boot_cmd_pkg::CMD_ERASE_ALL,
      boot_cmd_pkg::CMD_RD_STATUS, boot_cmd_pkg::CMD_CLR_STATUS,
      boot_cmd_pkg::CMD_RD_LOCK,   boot_cmd_pkg::CMD_LOCK_PROG,
      boot_cmd_pkg::CMD_LOCK_EN,   boot_cmd_pkg::CMD_LOCK_DIS,
      boot_cmd_pkg::CMD_ID_CHECK,  boot_cmd_pkg::CMD_DOWNLOAD,
      boot_cmd_pkg::CMD_VERSION,   boot_cmd_pkg::CMD_BOOT_OUT,
      boot_cmd_pkg::CMD_RD_CHECK:  return 1'b1;
      default: return c[7:2] == boot_cmd_pkg::CMD_BAUD_HI;
    endcase
  endfunction

  // One byte of CRC, most significant bit first
  function automatic logic [15:0] crc_next(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ boot_cmd_pkg::CRC_POLY)
                         : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // Acceptance gate on the first byte
  assign cmd_ok = known(RX_DATA_I) &&
                  (BLANK_I || id_q == boot_cmd_pkg::ID_OK ||
                   RX_DATA_I == boot_cmd_pkg::CMD_RD_STATUS ||
                   RX_DATA_I == boot_cmd_pkg::CMD_ID_CHECK ||
                   RX_DATA_I == boot_cmd_pkg::CMD_VERSION ||
                   RX_DATA_I[7:2] == boot_cmd_pkg::CMD_BAUD_HI);

  // Receive handshake; held low while an operation is pending
  assign RX_READY_O = state_q inside {boot_cmd_pkg::S_IDLE,
                                      boot_cmd_pkg::S_HDR,
                                      boot_cmd_pkg::S_CONF,
                                      boot_cmd_pkg::S_DIN};
  assign rx_take    = RX_VALID_I && RX_READY_O;

  // Secondary status; receive time-out is not detected here
  assign sec_status = {boot_q, 2'b00, sum_ok_q, id_q, 2'b00};
  assign out_mem    = cmd_q == boot_cmd_pkg::CMD_PAGE_READ ||
                      cmd_q == boot_cmd_pkg::CMD_BOOT_OUT ||
                      cmd_q == boot_cmd_pkg::CMD_RD_LOCK;
  assign out_last   = cnt_q == out_len(cmd_q) - 16'h0001;
  assign ver_idx    = 3'h7 - cnt_q[2:0];

  // Reply bytes that the parser makes itself
  always_comb
  begin
    local_byte = cmd_q;
    if (cmd_q == boot_cmd_pkg::CMD_RD_STATUS)
      local_byte = cnt_q[0] ? sec_status : PRIMARY_STATUS_I;
    else if (cmd_q == boot_cmd_pkg::CMD_VERSION)
      local_byte = boot_cmd_pkg::VERSION[{ver_idx, 3'b000} +: 8];
    else if (cmd_q == boot_cmd_pkg::CMD_RD_CHECK)
      local_byte = cnt_q[0] ? crc_q[15:8] : crc_q[7:0];
  end

  // Push into the reply buffer; reads only start with room left
  assign push      = (state_q == boot_cmd_pkg::S_OUT && !full && !out_mem) ||
                     (state_q == boot_cmd_pkg::S_RDW && MEM_ACK_I);
  assign push_data = state_q == boot_cmd_pkg::S_RDW ? MEM_RDATA_I
                                                    : local_byte;

  // Command sequencer
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      state_q  <= boot_cmd_pkg::S_IDLE;
      cmd_q    <= 8'h00;
      cnt_q    <= 16'h0000;
      len_q    <= 16'h0000;
      addr_q   <= 24'h000000;
      maddr_q  <= 24'h000000;
      byte_q   <= 8'h00;
      chk_q    <= 8'h00;
      sum_q    <= 8'h00;
      op_q     <= boot_cmd_pkg::OP_RD_FLASH;
      final_q  <= 1'b0;
      req_q    <= 1'b0;
      busy_q   <= 1'b0;
      mis_q    <= 1'b0;
      id_q     <= boot_cmd_pkg::ID_NONE;
      boot_q   <= 1'b0;
      sum_ok_q <= 1'b0;
    end
    else
    begin
      req_q <= 1'b0;
      unique case (state_q)
        boot_cmd_pkg::S_IDLE:
          if (rx_take && cmd_ok)
          begin
            cmd_q   <= RX_DATA_I;
            cnt_q   <= 16'h0000;
            maddr_q <= addr_q;
            final_q <= 1'b1;
            if (hdr_len(RX_DATA_I) != 16'h0000)
              state_q <= boot_cmd_pkg::S_HDR;
            else if (RX_DATA_I == boot_cmd_pkg::CMD_ERASE_ALL)
              state_q <= boot_cmd_pkg::S_CONF;
            else if (RX_DATA_I == boot_cmd_pkg::CMD_CLR_STATUS ||
                     RX_DATA_I == boot_cmd_pkg::CMD_LOCK_EN ||
                     RX_DATA_I == boot_cmd_pkg::CMD_LOCK_DIS)
            begin
              req_q   <= 1'b1;
              busy_q  <= 1'b1;
              op_q    <= RX_DATA_I == boot_cmd_pkg::CMD_CLR_STATUS ?
                         boot_cmd_pkg::OP_CLR_STATUS :
                         RX_DATA_I == boot_cmd_pkg::CMD_LOCK_EN ?
                         boot_cmd_pkg::OP_LOCK_EN :
                         boot_cmd_pkg::OP_LOCK_DIS;
              state_q <= boot_cmd_pkg::S_MEMW;
            end
            else
              state_q <= boot_cmd_pkg::S_OUT;
          end
        boot_cmd_pkg::S_HDR:
          if (rx_take)
          begin
            cnt_q <= cnt_q + 16'h0001;
            if (cmd_q == boot_cmd_pkg::CMD_DOWNLOAD)
            begin
              if (cnt_q[1:0] == 2'h0) len_q[7:0]  <= RX_DATA_I;
              if (cnt_q[1:0] == 2'h1) len_q[15:8] <= RX_DATA_I;
              if (cnt_q[1:0] == 2'h2) chk_q       <= RX_DATA_I;
            end
            else if (cmd_q == boot_cmd_pkg::CMD_ID_CHECK)
            begin
              if (cnt_q[1:0] == 2'h3) len_q <= {8'h00, RX_DATA_I};
              else addr_q[{cnt_q[1:0], 3'b000} +: 8] <= RX_DATA_I;
            end
            else if (cnt_q[0])
              addr_q[23:16] <= RX_DATA_I;
            else
              addr_q[15:8] <= RX_DATA_I;
            if (cnt_q == hdr_len(cmd_q) - 16'h0001)
            begin
              cnt_q   <= 16'h0000;
              sum_q   <= 8'h00;
              mis_q   <= 1'b0;
              state_q <= boot_cmd_pkg::S_OUT;
              if (cmd_q == boot_cmd_pkg::CMD_PAGE_PROG)
              begin
                len_q   <= boot_cmd_pkg::PAGE_LEN;
                state_q <= boot_cmd_pkg::S_DIN;
              end
              else if (cmd_q == boot_cmd_pkg::CMD_BLK_ERASE ||
                       cmd_q == boot_cmd_pkg::CMD_LOCK_PROG)
                state_q <= boot_cmd_pkg::S_CONF;
              else if (cmd_q == boot_cmd_pkg::CMD_ID_CHECK)
                state_q <= RX_DATA_I == 8'h00 ? boot_cmd_pkg::S_IDLE
                                              : boot_cmd_pkg::S_DIN;
              else if (cmd_q == boot_cmd_pkg::CMD_DOWNLOAD)
                state_q <= len_q == 16'h0000 ? boot_cmd_pkg::S_IDLE
                                             : boot_cmd_pkg::S_DIN;
            end
          end
        boot_cmd_pkg::S_CONF:
          if (rx_take)
          begin
            // A wrong confirm byte abandons the sequence
            state_q <= boot_cmd_pkg::S_IDLE;
            if (RX_DATA_I == boot_cmd_pkg::CONFIRM)
            begin
              req_q   <= 1'b1;
              busy_q  <= 1'b1;
              maddr_q <= addr_q;
              op_q    <= cmd_q == boot_cmd_pkg::CMD_ERASE_ALL ?
                         boot_cmd_pkg::OP_ERASE_ALL :
                         cmd_q == boot_cmd_pkg::CMD_LOCK_PROG ?
                         boot_cmd_pkg::OP_LOCK_PROG :
                         boot_cmd_pkg::OP_ERASE_BLK;
              state_q <= boot_cmd_pkg::S_MEMW;
            end
          end
        boot_cmd_pkg::S_DIN:
          if (rx_take)
          begin
            byte_q  <= RX_DATA_I;
            sum_q   <= sum_q + RX_DATA_I;
            req_q   <= 1'b1;
            final_q <= 1'b0;
            maddr_q <= {addr_q[23:8], cnt_q[7:0]};
            op_q    <= boot_cmd_pkg::OP_WR_BYTE;
            if (cmd_q == boot_cmd_pkg::CMD_ID_CHECK)
              op_q <= boot_cmd_pkg::OP_RD_ID;
            if (cmd_q == boot_cmd_pkg::CMD_DOWNLOAD)
            begin
              op_q    <= boot_cmd_pkg::OP_DL_BYTE;
              maddr_q <= {8'h00, cnt_q};
            end
            state_q <= boot_cmd_pkg::S_MEMW;
          end
        boot_cmd_pkg::S_MEMW:
          if (MEM_ACK_I)
          begin
            state_q <= boot_cmd_pkg::S_DIN;
            if (final_q)
            begin
              busy_q  <= 1'b0;
              state_q <= boot_cmd_pkg::S_IDLE;
            end
            else
            begin
              cnt_q <= cnt_q + 16'h0001;
              if (cmd_q == boot_cmd_pkg::CMD_ID_CHECK &&
                  MEM_RDATA_I != byte_q)
                mis_q <= 1'b1;
              if (cnt_q == len_q - 16'h0001)
              begin
                state_q <= boot_cmd_pkg::S_IDLE;
                final_q <= 1'b1;
                maddr_q <= addr_q;
                if (cmd_q == boot_cmd_pkg::CMD_PAGE_PROG)
                begin
                  // Busy covers the page write up to the next page
                  req_q   <= 1'b1;
                  busy_q  <= 1'b1;
                  op_q    <= boot_cmd_pkg::OP_PROG_PAGE;
                  state_q <= boot_cmd_pkg::S_MEMW;
                end
                else if (cmd_q == boot_cmd_pkg::CMD_ID_CHECK)
                  id_q <= (mis_q || MEM_RDATA_I != byte_q) ?
                          boot_cmd_pkg::ID_BAD : boot_cmd_pkg::ID_OK;
                else
                begin
                  boot_q   <= sum_q == chk_q;
                  sum_ok_q <= sum_q == chk_q;
                  if (sum_q == chk_q)
                  begin
                    req_q   <= 1'b1;
                    busy_q  <= 1'b1;
                    op_q    <= boot_cmd_pkg::OP_DL_RUN;
                    state_q <= boot_cmd_pkg::S_MEMW;
                  end
                end
              end
            end
          end
        boot_cmd_pkg::S_OUT:
          if (!full)
          begin
            if (out_mem)
            begin
              req_q   <= 1'b1;
              maddr_q <= {addr_q[23:8], cnt_q[7:0]};
              op_q    <= cmd_q == boot_cmd_pkg::CMD_BOOT_OUT ?
                         boot_cmd_pkg::OP_RD_BOOT :
                         cmd_q == boot_cmd_pkg::CMD_RD_LOCK ?
                         boot_cmd_pkg::OP_RD_LOCK :
                         boot_cmd_pkg::OP_RD_FLASH;
              if (cmd_q == boot_cmd_pkg::CMD_RD_LOCK)
                maddr_q <= addr_q;
              state_q <= boot_cmd_pkg::S_RDW;
            end
            else
            begin
              cnt_q <= cnt_q + 16'h0001;
              if (out_last)
                state_q <= boot_cmd_pkg::S_IDLE;
            end
          end
        boot_cmd_pkg::S_RDW:
          if (MEM_ACK_I)
          begin
            cnt_q   <= cnt_q + 16'h0001;
            state_q <= out_last ? boot_cmd_pkg::S_IDLE
                                : boot_cmd_pkg::S_OUT;
          end
        default:
          state_q <= boot_cmd_pkg::S_IDLE;
      endcase
    end
  end

  // Check data over page program bytes; cleared after it is read out
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      crc_q <= boot_cmd_pkg::CRC_INIT;
    else if (push && out_last && cmd_q == boot_cmd_pkg::CMD_RD_CHECK)
      crc_q <= boot_cmd_pkg::CRC_INIT;
    else if (state_q == boot_cmd_pkg::S_DIN && rx_take &&
             cmd_q == boot_cmd_pkg::CMD_PAGE_PROG)
      crc_q <= crc_next(crc_q, RX_DATA_I);
  end

  // Baud changes once the echo byte is queued behind older replies
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      baud_q <= boot_cmd_pkg::BAUD_RST;
    else if (push && cmd_q[7:2] == boot_cmd_pkg::CMD_BAUD_HI)
      baud_q <= cmd_q[1:0];
  end

  // Two-entry reply buffer; a stalled transmitter holds the parser
  assign full       = fill_q == 2'h2;
  assign pop        = TX_VALID_O && TX_READY_I;
  assign TX_VALID_O = fill_q != 2'h0;
  assign TX_DATA_O  = buf_q[rd_q];

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      fill_q   <= 2'h0;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      buf_q[0] <= 8'h00;
      buf_q[1] <= 8'h00;
    end
    else
    begin
      if (push)
      begin
        buf_q[wr_q] <= push_data;
        wr_q        <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
    end
  end

  assign BUSY_O      = busy_q;
  assign BAUD_SEL_O  = baud_q;
  assign MEM_REQ_O   = req_q;
  assign MEM_OP_O    = op_q;
  assign MEM_ADDR_O  = maddr_q;
  assign MEM_WDATA_O = byte_q;

endmodule // boot_cmd_parser

// file: hw/boot_cmd_pkg.sv
// Constants, codes and types of the serial boot command parser
package boot_cmd_pkg;

  // Command codes carried in the first byte of a sequence
  localparam logic [7:0] CMD_PAGE_READ  = 8'hff;
  localparam logic [7:0] CMD_PAGE_PROG  = 8'h41;
  localparam logic [7:0] CMD_BLK_ERASE  = 8'h20;
  localparam logic [7:0] CMD_ERASE_ALL  = 8'ha7;
  localparam logic [7:0] CMD_RD_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] CMD_RD_LOCK    = 8'h71;
  localparam logic [7:0] CMD_LOCK_PROG  = 8'h77;
  localparam logic [7:0] CMD_LOCK_EN    = 8'h7a;
  localparam logic [7:0] CMD_LOCK_DIS   = 8'h75;
  localparam logic [7:0] CMD_ID_CHECK   = 8'hf5;
  localparam logic [7:0] CMD_DOWNLOAD   = 8'hfa;
  localparam logic [7:0] CMD_VERSION    = 8'hfb;
  localparam logic [7:0] CMD_BOOT_OUT   = 8'hfc;
  localparam logic [7:0] CMD_RD_CHECK   = 8'hfd;
  // Baud commands b0..b3 share these upper six bits
  localparam logic [5:0] CMD_BAUD_HI    = 6'h2c;
  localparam logic [7:0] CONFIRM        = 8'hd0;

  // Byte counts of the phases of a sequence
  localparam logic [15:0] HDR_ADDR_LEN  = 16'h0002;
  localparam logic [15:0] HDR_DL_LEN    = 16'h0003;
  localparam logic [15:0] HDR_ID_LEN    = 16'h0004;
  localparam logic [15:0] PAGE_LEN      = 16'h0100;
  localparam logic [15:0] VER_LEN       = 16'h0008;
  localparam logic [15:0] PAIR_LEN      = 16'h0002;
  localparam logic [15:0] ONE_LEN       = 16'h0001;

  // Version text, eight ASCII characters (arbitrary value)
  localparam logic [63:0] VERSION       = 64'h424f4f54_312e3030;

  // Secondary status layout
  localparam int SEC_BOOT_DONE = 7;
  localparam int SEC_SUM_OK    = 4;
  localparam int SEC_ID_LSB    = 2;
  localparam logic [1:0] ID_NONE = 2'h0;
  localparam logic [1:0] ID_BAD  = 2'h1;
  localparam logic [1:0] ID_OK   = 2'h3;

  // Check data CRC
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [1:0]  BAUD_RST = 2'h0;

  // Operations requested from the flash controller
  typedef enum logic [3:0] {
    OP_RD_FLASH   = 4'h0,
    OP_RD_BOOT    = 4'h1,
    OP_RD_LOCK    = 4'h2,
    OP_RD_ID      = 4'h3,
    OP_WR_BYTE    = 4'h4,
    OP_PROG_PAGE  = 4'h5,
    OP_ERASE_BLK  = 4'h6,
    OP_ERASE_ALL  = 4'h7,
    OP_LOCK_PROG  = 4'h8,
    OP_LOCK_EN    = 4'h9,
    OP_LOCK_DIS   = 4'ha,
    OP_CLR_STATUS = 4'hb,
    OP_DL_BYTE    = 4'hc,
    OP_DL_RUN     = 4'hd
  } mem_op_t;

  // Parser states
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_HDR  = 7'h02,
    S_CONF = 7'h04,
    S_DIN  = 7'h08,
    S_MEMW = 7'h10,
    S_OUT  = 7'h20,
    S_RDW  = 7'h40
  } state_t;

endpackage

// file: verif/boot_cmd_parser_props.sv
// Port checker of the boot command parser
`timescale 1ns/1ps
module boot_cmd_parser_props (
  input wire logic       CLOCK_I,    // Clock
  input wire logic       RST_I,      // Reset
  input wire logic       TX_VALID_O, // Reply valid
  input wire logic [7:0] TX_DATA_O,  // Reply byte
  input wire logic       TX_READY_I, // Taker ready
  input wire logic       RX_READY_O, // Parser ready
  input wire logic       BUSY_O,     // Busy pin
  input wire logic [1:0] BAUD_SEL_O, // Rate select
  input wire logic       MEM_REQ_O,  // Request
  input wire logic [3:0] MEM_OP_O,   // Operation
  input wire logic       MEM_ACK_I   // Done
);
  default clocking @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);
  // Terminal operations raise busy no later than one cycle on
  sequence busy_soon;
    ##[0:1] BUSY_O;
  endsequence
  req_pulse_a: assert property (MEM_REQ_O |=> !MEM_REQ_O)
    else $error("request wider than one cycle");
  tx_hold_a: assert property (TX_VALID_O && !TX_READY_I |=>
    TX_VALID_O && $stable(TX_DATA_O)) else $error("reply dropped");
  busy_drop_a: assert property (BUSY_O && MEM_ACK_I |=> !BUSY_O)
    else $error("busy not released");
  busy_gate_a: assert property (BUSY_O |-> !RX_READY_O)
    else $error("byte taken while busy");
  prog_busy_a: assert property (MEM_REQ_O &&
    MEM_OP_O == boot_cmd_pkg::OP_PROG_PAGE |-> busy_soon)
    else $error("no busy on page write");
  erase_busy_a: assert property (MEM_REQ_O &&
    MEM_OP_O == boot_cmd_pkg::OP_ERASE_BLK |-> busy_soon)
    else $error("no busy on block erase");
  all_busy_a: assert property (MEM_REQ_O &&
    MEM_OP_O == boot_cmd_pkg::OP_ERASE_ALL |-> busy_soon)
    else $error("no busy on full erase");
  baud_echo_a: assert property ($changed(BAUD_SEL_O) |->
    TX_VALID_O && TX_DATA_O == {boot_cmd_pkg::CMD_BAUD_HI, BAUD_SEL_O})
    else $error("rate changed without echo");
endmodule // boot_cmd_parser_props
bind boot_cmd_parser boot_cmd_parser_props props_inst (.CLOCK_I(CLOCK_I),
  .RST_I(RST_I), .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O),
  .TX_READY_I(TX_READY_I), .RX_READY_O(RX_READY_O), .BUSY_O(BUSY_O),
  .BAUD_SEL_O(BAUD_SEL_O), .MEM_REQ_O(MEM_REQ_O), .MEM_OP_O(MEM_OP_O),
  .MEM_ACK_I(MEM_ACK_I));

// file: verif/flash_stub.sv
// Flash controller stand-in answering parser requests
`timescale 1ns/1ps
module flash_stub #(
  parameter int DLY = 3 // Request to done takes one cycle more than this
) (
  input  wire logic        clk_i,  // Clock
  input  wire logic        rst_i,  // Reset
  input  wire logic        req_i,  // Request pulse
  input  wire logic [23:0] addr_i, // Address
  output logic             ack_o,  // Done pulse
  output logic      [7:0]  rdata_o // Read data
);
  int cnt_q;
  // Data toggles outside the ack cycle so a late sample cannot pass
  always_ff @(posedge clk_i)
  begin
    ack_o   <= 1'b0;
    rdata_o <= ~rdata_o;
    if (rst_i)
    begin
      cnt_q   <= 0;
      rdata_o <= 8'h00;
    end
    else if (req_i)
      cnt_q <= DLY;
    else if (cnt_q > 1)
      cnt_q <= cnt_q - 1;
    else if (cnt_q == 1)
    begin
      cnt_q   <= 0;
      ack_o   <= 1'b1;
      rdata_o <= addr_i[7:0] ^ addr_i[15:8];
    end
  end
endmodule // flash_stub

// file: verif/uart_flash_boot_command_parser_test.sv
// Self-checking bench of the boot command parser
`timescale 1ns/1ps
module uart_flash_boot_command_parser_test;
  logic        CLOCK_I, RST_I, RX_VALID_I, RX_READY_O, TX_VALID_O;
  logic        TX_READY_I, BUSY_O, BLANK_I, MEM_REQ_O, MEM_ACK_I;
  logic [7:0]  RX_DATA_I, TX_DATA_O, MEM_WDATA_O, MEM_RDATA_I;
  logic [1:0]  BAUD_SEL_O;
  logic [3:0]  MEM_OP_O;
  logic [23:0] MEM_ADDR_O;
  int          err_total, comparisons, cyc;
  boot_cmd_parser boot_cmd_parser_inst (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
    .RX_VALID_I(RX_VALID_I), .RX_DATA_I(RX_DATA_I), .RX_READY_O(RX_READY_O),
    .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O), .TX_READY_I(TX_READY_I),
    .BUSY_O(BUSY_O), .BAUD_SEL_O(BAUD_SEL_O), .BLANK_I(BLANK_I),
    .PRIMARY_STATUS_I(8'h5a), .MEM_REQ_O(MEM_REQ_O), .MEM_OP_O(MEM_OP_O),
    .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O),
    .MEM_ACK_I(MEM_ACK_I), .MEM_RDATA_I(MEM_RDATA_I));
  flash_stub flash_stub_inst (.clk_i(CLOCK_I), .rst_i(RST_I),
    .req_i(MEM_REQ_O), .addr_i(MEM_ADDR_O), .ack_o(MEM_ACK_I),
    .rdata_o(MEM_RDATA_I));
  task automatic stop_test();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Valid stays up between bytes; idle drops it one edge later
  task automatic send(input logic [7:0] b);
    @(negedge CLOCK_I);
    RX_VALID_I = 1'b1;
    RX_DATA_I  = b;
    do @(posedge CLOCK_I); while (RX_READY_O !== 1'b1);
  endtask
  task automatic idle();
    @(negedge CLOCK_I);
    RX_VALID_I = 1'b0;
  endtask
  // Ready drops after each byte, so the reply buffer sees stalls
  task automatic recv(input logic [7:0] exp);
    @(negedge CLOCK_I);
    TX_READY_I = 1'b1;
    do @(posedge CLOCK_I); while (TX_VALID_O !== 1'b1);
    chk("reply", exp, TX_DATA_O);
    @(negedge CLOCK_I);
    TX_READY_I = 1'b0;
  endtask
  task automatic busy_cycle();
    int n;
    n = 0;
    while (BUSY_O !== 1'b1 && n < 600)
    begin
      @(posedge CLOCK_I);
      n++;
    end
    chk("busy high", 8'h01, {7'h00, BUSY_O});
    while (BUSY_O !== 1'b0 && n < 600)
    begin
      @(posedge CLOCK_I);
      n++;
    end
    chk("busy low", 8'h00, {7'h00, BUSY_O});
  endtask
  task automatic t_locked();
    send(8'hff);
    send(8'h00);
    send(8'h70);
    idle();
    recv(8'h5a);
    recv(8'h00);
    send(8'hfb);
    idle();
    for (int i = 7; i >= 0; i--)
      recv(boot_cmd_pkg::VERSION[i*8 +: 8]);
  endtask
  // Stub answers an ID read with index xor A8..A15, here 12
  task automatic t_id();
    send(8'hf5);
    send(8'h00);
    send(8'h12);
    send(8'h34);
    send(8'h01);
    send(8'h12);
    send(8'h70);
    idle();
    recv(8'h5a);
    recv(8'h0c);
    send(8'h7a);
    idle();
    busy_cycle();
    send(8'h75);
    idle();
    busy_cycle();
    send(8'h71);
    send(8'h12);
    send(8'h34);
    idle();
    recv(8'h12);
  endtask
  task automatic t_load();
    send(8'hfa);
    send(8'h01);
    send(8'h00);
    send(8'h5a);
    send(8'h5a);
    idle();
    busy_cycle();
    send(8'h70);
    idle();
    recv(8'h5a);
    recv(8'h9c);
  endtask
  task automatic t_baud();
    for (int i = 3; i >= 0; i--)
    begin
      send({6'h2c, i[1:0]});
      idle();
      recv({6'h2c, i[1:0]});
      chk("rate", {6'h00, i[1:0]}, {6'h00, BAUD_SEL_O});
    end
  endtask
  task automatic t_read(input logic [7:0] code);
    send(code);
    send(8'h12);
    send(8'h34);
    idle();
    for (int i = 0; i < 256; i++)
      recv(i[7:0] ^ 8'h12);
  endtask
  task automatic t_prog();
    logic [15:0] crc;
    crc = 16'h0000;
    send(8'h41);
    send(8'h12);
    send(8'h34);
    for (int i = 0; i < 256; i++)
    begin
      send(i[7:0]);
      @(negedge CLOCK_I);
      chk("write data", i[7:0], MEM_WDATA_O);
      chk("write addr", i[7:0], MEM_ADDR_O[7:0]);
      for (int k = 7; k >= 0; k--)
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ i[k]) ? 16'h1021 : 16'h0000);
    end
    idle();
    busy_cycle();
    send(8'hfd);
    idle();
    recv(crc[7:0]);
    recv(crc[15:8]);
  endtask
  task automatic t_erase();
    send(8'h20);
    send(8'h12);
    send(8'h34);
    send(8'hd0);
    idle();
    busy_cycle();
    send(8'ha7);
    send(8'hd0);
    idle();
    busy_cycle();
    send(8'h77);
    send(8'h12);
    send(8'h34);
    send(8'hd0);
    idle();
    busy_cycle();
    send(8'h50);
    idle();
    busy_cycle();
  endtask
  // Free-running clock and a cycle ceiling against hangs
  initial
  begin
    CLOCK_I = 1'b0;
    forever #10 CLOCK_I = ~CLOCK_I;
  end
  always @(posedge CLOCK_I)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test();
    end
  end
  initial
  begin
    RST_I      = 1'b1;
    RX_VALID_I = 1'b0;
    RX_DATA_I  = 8'h00;
    TX_READY_I = 1'b0;
    BLANK_I    = 1'b0;
    repeat (3) @(posedge CLOCK_I);
    @(negedge CLOCK_I);
    RST_I = 1'b0;
    t_locked();
    t_id();
    t_load();
    t_baud();
    BLANK_I = 1'b1;
    t_read(8'hff);
    t_read(8'hfc);
    t_prog();
    t_erase();
    stop_test();
  end
endmodule // uart_flash_boot_command_parser_test
